// file: rtl/can_rx_acceptance_filter.sv
// Overview of operation
// R1: filter SID bits must equal received SID
// R2: filter EID bits must equal received EID
// R3: type check on: select bit picks type
// R4: type check off: ignore frame-type select
// R5: mask source 00/01/10 mask, 11 none
// R6: mask SID bit 1 compares, 0 ignores
// R7: mask EID bit 1 compares, 0 ignores
// R8: mask mode 1 restricts frame type
// R9: mode 0: match SID or SID/EID
// R10: thirty-two full flags set on write
// R11: software clears full flags after emptying
// R12: overflow set when writing full buffer
// R13: software clears overflow flags, reset zero
// R14: std register bits 4,2 read zero
// R15: sixteen independent filters with own registers
// R16: disabled filters never accept
// R17: buffer pointer selects buffer, 1111 FIFO
// R18: store records number of hitting filter
// R19: lowest-numbered matching filter wins
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module can_rx_acceptance_filter (
    input  wire logic                              mclk,         // 250 MHz clock
    input  wire logic                              rst,          // synchronous reset, active high
    input  wire logic [can_rx_filter_pkg::ADDR_W-1:0] addr,      // register index
    input  wire logic [can_rx_filter_pkg::DATA_W-1:0] wdata,     // write data
    input  wire logic                              wr,           // write strobe
    input  wire logic                              rd,           // read strobe
    output logic      [can_rx_filter_pkg::DATA_W-1:0] rdata,     // read data, cycle after rd
    input  wire logic                              frame_valid,  // received frame strobe
    input  wire can_rx_filter_pkg::rx_frame_t      frame,        // received identifier
    input  wire logic [4:0]                        fifo_buf_idx, // next fifo buffer
    output logic                                   store_valid,  // buffer write pulse
    output can_rx_filter_pkg::rx_store_t           store,        // buffer write target
    output logic                                   irq           // level interrupt
);
    import can_rx_filter_pkg::*;

    // buffer pointer and mask-source packing
    localparam int PTR_W        = 4;
    localparam int SRC_W        = 2;
    localparam int NUM_PTR_REGS = NUM_FILTERS * PTR_W / DATA_W;

    logic [15:0] filter_std_reg [NUM_FILTERS];
    logic [15:0] filter_ext_reg [NUM_FILTERS];
    logic [15:0] mask_std_reg   [NUM_MASKS];
    logic [15:0] mask_ext_reg   [NUM_MASKS];
    logic [31:0] mask_sel_reg;
    logic [15:0] enable_reg;
    logic [63:0] buf_ptr_reg;
    logic [31:0] full_reg;
    logic [31:0] ovf_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [15:0] rdata_reg;
    logic        store_valid_reg;
    rx_store_t   store_reg;

    logic [NUM_FILTERS-1:0] hit;
    logic        any_hit;
    logic [3:0]  win;
    logic [3:0]  win_ptr;
    logic [4:0]  target;
    logic        accept;
    logic        overflow;
    logic [31:0] full_clr;
    logic [31:0] ovf_clr;

    // one filter against one frame with the mask it selects
    function automatic logic filter_match(input logic [15:0] fstd, input logic [15:0] fext,
                                          input logic [15:0] mstd, input logic [15:0] mext,
                                          input logic no_mask, input rx_frame_t f);
        logic [10:0] msid;
        logic [17:0] meid;
        logic        mode;
        logic        sid_ok;
        logic        eid_ok;
        msid   = no_mask ? '1 : mstd[SID_HI:SID_LO];                          // R5 R6
        meid   = no_mask ? '1 : {mstd[EIDH_HI:EIDH_LO], mext};                // R5 R7
        mode   = no_mask ? 1'b1 : mstd[TYPE_BIT];
        sid_ok = ((fstd[SID_HI:SID_LO] ^ f.sid) & msid) == '0;                // R1
        eid_ok = (({fstd[EIDH_HI:EIDH_LO], fext} ^ f.eid) & meid) == '0;      // R2
        if (mode) begin
            filter_match = (fstd[TYPE_BIT] == f.ext) && sid_ok && (!f.ext || eid_ok); // R3 R8
        end else begin
            filter_match = sid_ok && (!f.ext || eid_ok);                      // R4 R9
        end
    endfunction

    function automatic logic [3:0] ptr_of(input logic [63:0] ptrs, input logic [3:0] idx);
        ptr_of = ptrs[idx * PTR_W +: PTR_W];
    endfunction

    generate
        for (genvar i = 0; i < NUM_FILTERS; i++) begin : g_filter              // R15
            logic [1:0] src;
            logic [1:0] mi;
            assign src = mask_sel_reg[SRC_W*i +: SRC_W];
            assign mi  = (src == MASK_SRC_NONE) ? 2'h0 : src;
            assign hit[i] = enable_reg[i] && filter_match(filter_std_reg[i], filter_ext_reg[i],  // R16
                            mask_std_reg[mi], mask_ext_reg[mi], src == MASK_SRC_NONE, frame);

            // a type-checked hit never crosses frame types
            type_check_a: assert property (@(posedge mclk) disable iff (rst) // R3 R8
                hit[i] && (src == MASK_SRC_NONE || mask_std_reg[mi][TYPE_BIT]) |-> filter_std_reg[i][TYPE_BIT] == frame.ext)
                else $error("type-checked filter hit a frame of the other type");
        end
    endgenerate

    always_comb begin
        win = 4'h0;
        for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                win = 4'(i);                                                   // R19
            end
        end
    end

    assign any_hit  = |hit;
    assign win_ptr  = ptr_of(buf_ptr_reg, win);
    assign target   = (win_ptr == PTR_TO_FIFO) ? fifo_buf_idx : {1'b0, win_ptr};  // R17
    assign accept   = frame_valid && any_hit;
    assign overflow = accept && full_reg[target];

    // software clears flags by writing zero to them
    always_comb begin
        full_clr = '0;
        ovf_clr  = '0;
        if (wr) begin
            case (addr)
                ADDR_FULL_LOW:  full_clr[15:0]  = ~wdata;                     // R11
                ADDR_FULL_HIGH: full_clr[31:16] = ~wdata;
                ADDR_OVF_LOW:   ovf_clr[15:0]   = ~wdata;                     // R13
                ADDR_OVF_HIGH:  ovf_clr[31:16]  = ~wdata;
                default: begin
                    full_clr = '0;
                end
            endcase
        end
    end

    // full and overflow flags, a set in the clear cycle wins
    always_ff @(posedge mclk) begin
        if (rst) begin
            full_reg <= '0;
            ovf_reg  <= '0;
        end else begin
            full_reg <= (full_reg & ~full_clr) | ((accept && !overflow) ? (32'h1 << target) : '0); // R10
            ovf_reg  <= (ovf_reg & ~ovf_clr) | (overflow ? (32'h1 << target) : '0);               // R12
        end
    end

    // buffer write request toward the message store
    always_ff @(posedge mclk) begin
        if (rst) begin
            store_valid_reg <= 1'b0;
            store_reg       <= '0;
        end else begin
            store_valid_reg <= accept && !overflow;
            if (accept) begin
                store_reg.buf_idx  <= target;
                store_reg.hit_code <= {1'b0, win};                            // R18
                store_reg.to_fifo  <= win_ptr == PTR_TO_FIFO;
            end
        end
    end

    // configuration registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < NUM_FILTERS; i++) begin
                filter_std_reg[i] <= ZERO16;
                filter_ext_reg[i] <= ZERO16;
            end
            for (int m = 0; m < NUM_MASKS; m++) begin
                mask_std_reg[m] <= ZERO16;
                mask_ext_reg[m] <= ZERO16;
            end
            mask_sel_reg <= '0;
            enable_reg   <= ENABLE_RESET;
            buf_ptr_reg  <= '0;
            irq_mask_reg <= '0;
        end else if (wr) begin
            for (int i = 0; i < NUM_FILTERS; i++) begin
                if (addr == ADDR_FILTER_STD_BASE + 8'(i)) begin
                    filter_std_reg[i] <= wdata & STD_ID_WMASK;               // R14
                end
                if (addr == ADDR_FILTER_EXT_BASE + 8'(i)) begin
                    filter_ext_reg[i] <= wdata;
                end
            end
            for (int m = 0; m < NUM_MASKS; m++) begin
                if (addr == ADDR_MASK_STD_BASE + 8'(m)) begin
                    mask_std_reg[m] <= wdata & STD_ID_WMASK;                 // R14
                end
                if (addr == ADDR_MASK_EXT_BASE + 8'(m)) begin
                    mask_ext_reg[m] <= wdata;
                end
            end
            for (int p = 0; p < NUM_PTR_REGS; p++) begin
                if (addr == ADDR_BUF_PTR_BASE + 8'(p)) begin
                    buf_ptr_reg[DATA_W*p +: DATA_W] <= wdata;
                end
            end
            if (addr == ADDR_MASK_SEL_LOW) begin
                mask_sel_reg[15:0] <= wdata;
            end
            if (addr == ADDR_MASK_SEL_HIGH) begin
                mask_sel_reg[31:16] <= wdata;
            end
            if (addr == ADDR_FILTER_ENABLE) begin
                enable_reg <= wdata;
            end
            if (addr == ADDR_IRQ_MASK) begin
                irq_mask_reg <= wdata[IRQ_W-1:0];
            end
        end
    end

    // interrupt status: set by events, write one to clear, set wins
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~((wr && addr == ADDR_IRQ_STATUS) ? wdata[IRQ_W-1:0] : '0))
                            | {overflow, accept && !overflow};
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // read port, data in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_reg <= ZERO16;
        end else if (rd) begin
            rdata_reg <= ZERO16;
            for (int i = 0; i < NUM_FILTERS; i++) begin
                if (addr == ADDR_FILTER_STD_BASE + 8'(i)) begin
                    rdata_reg <= filter_std_reg[i];
                end
                if (addr == ADDR_FILTER_EXT_BASE + 8'(i)) begin
                    rdata_reg <= filter_ext_reg[i];
                end
            end
            for (int m = 0; m < NUM_MASKS; m++) begin
                if (addr == ADDR_MASK_STD_BASE + 8'(m)) begin
                    rdata_reg <= mask_std_reg[m];
                end
                if (addr == ADDR_MASK_EXT_BASE + 8'(m)) begin
                    rdata_reg <= mask_ext_reg[m];
                end
            end
            for (int p = 0; p < NUM_PTR_REGS; p++) begin
                if (addr == ADDR_BUF_PTR_BASE + 8'(p)) begin
                    rdata_reg <= buf_ptr_reg[DATA_W*p +: DATA_W];
                end
            end
            case (addr)
                ADDR_MASK_SEL_LOW:  rdata_reg <= mask_sel_reg[15:0];
                ADDR_MASK_SEL_HIGH: rdata_reg <= mask_sel_reg[31:16];
                ADDR_FULL_LOW:      rdata_reg <= full_reg[15:0];
                ADDR_FULL_HIGH:     rdata_reg <= full_reg[31:16];
                ADDR_OVF_LOW:       rdata_reg <= ovf_reg[15:0];
                ADDR_OVF_HIGH:      rdata_reg <= ovf_reg[31:16];
                ADDR_FILTER_ENABLE: rdata_reg <= enable_reg;
                ADDR_IRQ_STATUS:    rdata_reg <= {14'h0000, irq_status_reg};
                ADDR_IRQ_MASK:      rdata_reg <= {14'h0000, irq_mask_reg};
                default: begin
                end
            endcase
        end
    end

    assign rdata       = rdata_reg;
    assign store_valid = store_valid_reg;
    assign store       = store_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // acceptance, priority and routing
    store_on_hit_a: assert property (frame_valid && any_hit && !full_reg[target] |=> store_valid) // R10
        else $error("accepted frame did not produce a buffer write");

    no_store_miss_a: assert property (!(frame_valid && any_hit) |=> !store_valid) // R16
        else $error("buffer write without a matching enabled filter");

    lowest_wins_a: assert property (store_valid |-> $past(hit) == ($past(hit) & ~((16'h1 << store.hit_code[3:0]) - 16'h1))) // R19
        else $error("a lower-numbered filter also matched");

    hit_code_a: assert property (store_valid |-> !store.hit_code[4] // R18
                                 && |($past(hit) & (16'h1 << store.hit_code[3:0])))
        else $error("stored filter number did not hit");

    disabled_a: assert property (store_valid |-> |($past(enable_reg) & (16'h1 << store.hit_code[3:0]))) // R16
        else $error("disabled filter produced a hit");

    fifo_route_a: assert property (store_valid && store.to_fifo |-> store.buf_idx == $past(fifo_buf_idx)) // R17
        else $error("fifo hit not routed to fifo buffer");

    local_route_a: assert property (store_valid && !store.to_fifo |-> store.buf_idx < {1'b0, PTR_TO_FIFO}) // R17
        else $error("pointer hit routed outside the direct buffers");

    store_hold_a: assert property (!accept |=> $stable(store))
        else $error("buffer write target changed without an accepted frame");

    // full and overflow flags
    full_set_a: assert property (store_valid |-> full_reg[store.buf_idx]) // R10
        else $error("full flag not set after buffer write");

    full_cause_a: assert property ((full_reg & ~$past(full_reg)) != '0 |-> store_valid) // R10
        else $error("full flag set without a buffer write");

    full_sticky_a: assert property (full_reg[0] && !(wr && addr == ADDR_FULL_LOW && !wdata[0]) |=> full_reg[0]) // R11
        else $error("full flag cleared without software write");

    full_hold_a: assert property (!(wr && (addr == ADDR_FULL_LOW || addr == ADDR_FULL_HIGH)) // R11
                                  |=> (full_reg & $past(full_reg)) == $past(full_reg))
        else $error("full flag dropped without software clear");

    ovf_set_a: assert property (frame_valid && any_hit && full_reg[target] |=> ovf_reg[$past(target)] && !store_valid) // R12
        else $error("overflow flag not set on write to full buffer");

    ovf_cause_a: assert property (!overflow |=> (ovf_reg & ~$past(ovf_reg)) == '0) // R12
        else $error("overflow flag set without a write to a full buffer");

    ovf_keeps_full_a: assert property (overflow && !wr |=> full_reg[$past(target)]) // R12
        else $error("full flag lost on overflow");

    ovf_hold_a: assert property (!(wr && (addr == ADDR_OVF_LOW || addr == ADDR_OVF_HIGH)) // R13
                                 |=> (ovf_reg & $past(ovf_reg)) == $past(ovf_reg))
        else $error("overflow flag dropped without software clear");

    // register port and interrupt
    std_zero_a: assert property (rd && addr == ADDR_FILTER_STD_BASE |=> rdata[4] == 1'b0 && rdata[2] == 1'b0) // R14
        else $error("unimplemented standard-identifier bits read nonzero");

    mask_std_zero_a: assert property (rd && addr == ADDR_MASK_STD_BASE |=> rdata[4] == 1'b0 && rdata[2] == 1'b0) // R14
        else $error("unimplemented mask bits read nonzero");

    sel_read_a: assert property (rd && addr == ADDR_MASK_SEL_LOW |=> rdata == $past(mask_sel_reg[DATA_W-1:0])) // R5
        else $error("mask select register read back wrong");

    enable_write_a: assert property (wr && addr == ADDR_FILTER_ENABLE |=> enable_reg == $past(wdata)) // R16
        else $error("filter enable write did not land");

    enable_read_a: assert property (rd && addr == ADDR_FILTER_ENABLE |=> rdata == $past(enable_reg)) // R16
        else $error("filter enable read back wrong");

    unmapped_a: assert property (rd && addr > ADDR_IRQ_MASK |=> rdata == ZERO16)
        else $error("unmapped register read nonzero");

    rdata_hold_a: assert property (!rd |=> $stable(rdata))
        else $error("read data changed without a read strobe");

    status_read_a: assert property (rd && addr == ADDR_IRQ_STATUS |=> rdata[IRQ_W-1:0] == $past(irq_status_reg))
        else $error("interrupt status read back wrong");

    accept_irq_a: assert property (frame_valid && any_hit && !full_reg[target] |=> irq_status_reg[IRQ_ACCEPT]) // R10
        else $error("accepted frame did not set its status bit");

    irq_clear_a: assert property (wr && addr == ADDR_IRQ_STATUS && wdata[IRQ_ACCEPT] && !accept
                                  |=> !irq_status_reg[IRQ_ACCEPT])
        else $error("status bit not cleared by writing one");

    irq_event_a: assert property (overflow && irq_mask_reg[IRQ_OVERFLOW] && !wr |=> irq) // R12
        else $error("unmasked overflow did not raise the interrupt");

    irq_quiet_a: assert property (irq_mask_reg == '0 |-> !irq)
        else $error("interrupt raised while all sources masked");

    irq_level_a: assert property (irq == ((irq_status_reg[IRQ_ACCEPT] && irq_mask_reg[IRQ_ACCEPT])
                                         || (irq_status_reg[IRQ_OVERFLOW] && irq_mask_reg[IRQ_OVERFLOW])))
        else $error("interrupt output disagrees with status and mask");

    accept_c: cover property (store_valid ##1 store_valid);
    overflow_c: cover property (frame_valid && any_hit && full_reg[target]);
    fifo_c: cover property (store_valid && store.to_fifo);
    multi_hit_c: cover property (frame_valid && $countones(hit) > 1);
    irq_c: cover property ($rose(irq));

endmodule // can_rx_acceptance_filter

// file: rtl/can_rx_filter_pkg.sv
package can_rx_filter_pkg;
    localparam int NUM_FILTERS  = 16;
    localparam int NUM_MASKS    = 3;
    localparam int NUM_BUFFERS  = 32;
    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 16;

    // register indices
    localparam logic [7:0] ADDR_FILTER_STD_BASE   = 8'h00;
    localparam logic [7:0] ADDR_FILTER_EXT_BASE   = 8'h10;
    localparam logic [7:0] ADDR_MASK_SEL_LOW      = 8'h20;
    localparam logic [7:0] ADDR_MASK_SEL_HIGH     = 8'h21;
    localparam logic [7:0] ADDR_MASK_STD_BASE     = 8'h22;
    localparam logic [7:0] ADDR_MASK_EXT_BASE     = 8'h25;
    localparam logic [7:0] ADDR_FULL_LOW          = 8'h28;
    localparam logic [7:0] ADDR_FULL_HIGH         = 8'h29;
    localparam logic [7:0] ADDR_OVF_LOW           = 8'h2A;
    localparam logic [7:0] ADDR_OVF_HIGH          = 8'h2B;
    localparam logic [7:0] ADDR_FILTER_ENABLE     = 8'h2C;
    localparam logic [7:0] ADDR_BUF_PTR_BASE      = 8'h2D;
    localparam logic [7:0] ADDR_IRQ_STATUS        = 8'h31;
    localparam logic [7:0] ADDR_IRQ_MASK          = 8'h32;

    // field layout of the standard-identifier registers
    localparam int SID_HI       = 15;
    localparam int SID_LO       = 5;
    localparam int TYPE_BIT     = 3;
    localparam int EIDH_HI      = 1;
    localparam int EIDH_LO      = 0;
    localparam logic [15:0] STD_ID_WMASK = 16'hFFEB;

    localparam logic [1:0]  MASK_SRC_NONE  = 2'h3;
    localparam logic [3:0]  PTR_TO_FIFO    = 4'hF;
    localparam logic [15:0] ENABLE_RESET   = 16'h003F;
    localparam logic [15:0] ZERO16         = 16'h0000;

    // interrupt status bits
    localparam int IRQ_ACCEPT   = 0;
    localparam int IRQ_OVERFLOW = 1;
    localparam int IRQ_W        = 2;

    typedef struct packed {
        logic [10:0] sid;
        logic [17:0] eid;
        logic        ext;     // 1: extended identifier frame
    } rx_frame_t;

    typedef struct packed {
        logic [4:0] buf_idx;
        logic [4:0] hit_code;
        logic       to_fifo;
    } rx_store_t;
endpackage

// file: tb/can_frame_source.sv
`timescale 1ns/1ps
module can_frame_source (
    input  wire logic                  mclk,         // clock
    output logic                       frame_valid,  // frame strobe
    output can_rx_filter_pkg::rx_frame_t frame,      // received identifier
    output logic [4:0]                 fifo_buf_idx  // next fifo buffer
);
    import can_rx_filter_pkg::*;

    initial begin
        frame_valid = 1'b0;
        frame = '0;
        fifo_buf_idx = 5'h00;
    end

    // one frame per call, strobe held for exactly one edge
    task automatic send(input rx_frame_t f, input logic [4:0] fidx);
        @(posedge mclk);
        frame_valid <= 1'b1;
        frame <= f;
        fifo_buf_idx <= fidx;
        @(posedge mclk);
        frame_valid <= 1'b0;
        // released lines carry the inverse so a stale identifier never matches by chance
        frame <= ~f;
    endtask
endmodule // can_frame_source

// file: tb/can_rx_acceptance_filter_tb.sv
`timescale 1ns/1ps
module can_rx_acceptance_filter_tb;
    import can_rx_filter_pkg::*;
    logic              mclk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 16'h0000;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic              frame_valid;
    rx_frame_t         frame;
    logic [4:0]        fifo_buf_idx;
    logic              store_valid;
    rx_store_t         store;
    logic              irq;
    int                mismatches = 0;
    int                n_compared = 0;
    int                cycles = 0;

    always #2 mclk = ~mclk;

    can_rx_acceptance_filter can_rx_acceptance_filter_inst (.mclk(mclk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .frame_valid(frame_valid), .frame(frame),
        .fifo_buf_idx(fifo_buf_idx), .store_valid(store_valid), .store(store), .irq(irq));
    can_frame_source can_frame_source_inst (.mclk(mclk), .frame_valid(frame_valid), .frame(frame),
        .fifo_buf_idx(fifo_buf_idx));

    task automatic fail(input string m);
        mismatches++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) fail($sformatf("value %h expected %h", got, exp));
    endtask

    task automatic wrr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [15:0] exp);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        check16(rdata, exp);
    endtask

    task automatic ic(input logic exp);
        #1;
        check16({15'h0000, irq}, {15'h0000, exp});
    endtask

    // send a frame and compare the store pulse and target in the following cycle
    task automatic fc(input logic [10:0] s, input logic [17:0] e, input logic x, input logic [4:0] f,
                      input logic v, input logic [10:0] st);
        can_frame_source_inst.send('{s, e, x}, f);
        #1;
        n_compared++;
        if (store_valid !== v || (v === 1'b1 && store !== st)) fail($sformatf("store %b %h", store_valid, store));
    endtask

    function automatic logic [15:0] sr(input logic [10:0] s, input logic t, input logic [1:0] e);
        return {s, 1'b0, t, 1'b0, e};
    endfunction

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail("timeout");
            end_of_test;
        end
    end

    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rc(ADDR_MASK_SEL_LOW, 16'h0000);
        rc(ADDR_FULL_LOW, 16'h0000);
        rc(ADDR_FULL_HIGH, 16'h0000);
        rc(ADDR_OVF_LOW, 16'h0000);
        rc(ADDR_OVF_HIGH, 16'h0000);
        rc(ADDR_FILTER_ENABLE, 16'h003F);
        wrr(ADDR_FILTER_STD_BASE, 16'hFFFF);
        rc(ADDR_FILTER_STD_BASE, 16'hFFEB);
        wrr(ADDR_MASK_STD_BASE, 16'hFFFF);
        rc(ADDR_MASK_STD_BASE, 16'hFFEB);
        wrr(8'h40, 16'hFFFF);
        rc(8'h40, 16'h0000);
        $display("test registers done");
        // filter 0 no mask, filter 1 mask 1, filter 2 no mask, filter 3 mask 2
        wrr(ADDR_FILTER_STD_BASE, sr(11'h123, 1'b0, 2'h0));
        wrr(ADDR_FILTER_EXT_BASE, 16'h0000);
        wrr(ADDR_MASK_SEL_LOW, 16'h00B7);
        wrr(ADDR_BUF_PTR_BASE, 16'h97F5);
        wrr(ADDR_FILTER_ENABLE, 16'h0001);
        fc(11'h122, 18'h00000, 1'b0, 5'h00, 1'b0, 11'h000);
        fc(11'h123, 18'h00000, 1'b1, 5'h00, 1'b0, 11'h000);
        fc(11'h123, 18'h00000, 1'b0, 5'h00, 1'b1, {5'h05, 5'h00, 1'h0});
        rc(ADDR_FULL_LOW, 16'h0020);
        fc(11'h123, 18'h00000, 1'b0, 5'h00, 1'b0, 11'h000);
        rc(ADDR_OVF_LOW, 16'h0020);
        rc(ADDR_FULL_LOW, 16'h0020);
        wrr(ADDR_FULL_LOW, 16'hFFDF);
        rc(ADDR_FULL_LOW, 16'h0000);
        wrr(ADDR_OVF_LOW, 16'hFFDF);
        rc(ADDR_OVF_LOW, 16'h0000);
        $display("test exact match done");
        wrr(ADDR_MASK_STD_BASE + 8'h01, 16'hFE00);
        wrr(ADDR_MASK_EXT_BASE + 8'h01, 16'h0000);
        wrr(ADDR_FILTER_STD_BASE + 8'h01, sr(11'h450, 1'b1, 2'h3));
        wrr(ADDR_FILTER_EXT_BASE + 8'h01, 16'hABCD);
        wrr(ADDR_FILTER_ENABLE, 16'h0002);
        fc(11'h45A, 18'h00000, 1'b1, 5'h14, 1'b1, {5'h14, 5'h01, 1'h1});
        fc(11'h45F, 18'h00000, 1'b0, 5'h15, 1'b1, {5'h15, 5'h01, 1'h1});
        fc(11'h470, 18'h00000, 1'b1, 5'h16, 1'b0, 11'h000);
        fc(11'h123, 18'h00000, 1'b0, 5'h16, 1'b0, 11'h000);
        wrr(ADDR_MASK_STD_BASE + 8'h01, 16'hFE08);
        fc(11'h45F, 18'h00000, 1'b0, 5'h16, 1'b0, 11'h000);
        fc(11'h45A, 18'h00000, 1'b1, 5'h16, 1'b1, {5'h16, 5'h01, 1'h1});
        wrr(ADDR_MASK_EXT_BASE + 8'h01, 16'h0001);
        wrr(ADDR_MASK_STD_BASE + 8'h01, 16'hFE09);
        fc(11'h45A, 18'h10000, 1'b1, 5'h17, 1'b0, 11'h000);
        fc(11'h45A, 18'h00001, 1'b1, 5'h17, 1'b0, 11'h000);
        fc(11'h45A, 18'h10001, 1'b1, 5'h17, 1'b1, {5'h17, 5'h01, 1'h1});
        rc(ADDR_FULL_HIGH, 16'h00F0);
        $display("test masks done");
        wrr(ADDR_FILTER_STD_BASE + 8'h02, sr(11'h055, 1'b0, 2'h0));
        wrr(ADDR_FILTER_ENABLE, 16'h000C);
        fc(11'h055, 18'h00000, 1'b0, 5'h00, 1'b1, {5'h07, 5'h02, 1'h0});
        wrr(ADDR_FILTER_ENABLE, 16'h0008);
        fc(11'h3AA, 18'h2AAAA, 1'b1, 5'h00, 1'b1, {5'h09, 5'h03, 1'h0});
        wrr(ADDR_FILTER_ENABLE, 16'h0004);
        fc(11'h3AA, 18'h2AAAA, 1'b1, 5'h00, 1'b0, 11'h000);
        rc(ADDR_FULL_LOW, 16'h0280);
        wrr(ADDR_FILTER_ENABLE, 16'h0010);
        fc(11'h001, 18'h00000, 1'b0, 5'h00, 1'b0, 11'h000);
        fc(11'h000, 18'h00000, 1'b0, 5'h00, 1'b1, {5'h00, 5'h04, 1'h0});
        $display("test priority done");
        rc(ADDR_IRQ_STATUS, 16'h0003);
        ic(1'b0);
        wrr(ADDR_IRQ_MASK, 16'h0002);
        ic(1'b1);
        wrr(ADDR_IRQ_STATUS, 16'h0002);
        ic(1'b0);
        rc(ADDR_IRQ_STATUS, 16'h0001);
        wrr(ADDR_IRQ_MASK, 16'h0003);
        ic(1'b1);
        wrr(ADDR_IRQ_STATUS, 16'h0001);
        ic(1'b0);
        $display("test interrupt done");
        end_of_test;
    end
endmodule // can_rx_acceptance_filter_tb
